//--- shared/srsp_pkg.sv
// shared constants for the sensor result, status and parameter map
package srsp_pkg;
	// byte addresses on the serial bus
	localparam logic [7:0] ADDR_AUX_LOW = 8'h2C;
	localparam logic [7:0] ADDR_AUX_HIGH = 8'h2D;
	localparam logic [7:0] ADDR_MAILBOX = 8'h2E;
	localparam logic [7:0] ADDR_CHIP_STATE = 8'h30;
	localparam logic [7:0] ADDR_KEY_FIRST = 8'h3B;
	localparam logic [7:0] ADDR_KEY_LAST = 8'h3E;
	// values after reset
	localparam logic [7:0] RST_AUX_LOW = 8'h00;
	localparam logic [7:0] RST_AUX_HIGH = 8'h00;
	localparam logic [7:0] RST_MAILBOX = 8'h00;
	localparam logic [31:0] RST_KEY = 32'h0000_0000;
	// chip state field positions
	localparam int STATE_AWAKE_BIT = 2;
	localparam int STATE_SUSPEND_BIT = 1;
	localparam int STATE_SLEEP_BIT = 0;
	// parameter memory layout
	localparam int PARAM_DEPTH = 32;
	localparam logic [4:0] PRM_BUS_ADDRESS = 5'h00;
	localparam logic [4:0] PRM_CHANNEL_LIST = 5'h01;
	localparam logic [4:0] PRM_LED12_SELECT = 5'h02;
	localparam logic [4:0] PRM_LED3_SELECT = 5'h03;
	localparam logic [4:0] PRM_RSVD_ZERO = 5'h04;
	localparam logic [4:0] PRM_PROX1_INPUT_SELECT = 5'h07;
	localparam logic [4:0] PRM_PROX2_INPUT_SELECT = 5'h08;
	localparam logic [4:0] PRM_PROX3_INPUT_SELECT = 5'h09;
	localparam logic [4:0] PRM_RSVD_A = 5'h0D;
	localparam logic [4:0] PRM_AUXILIARY_INPUT_SELECT = 5'h0F;
	localparam logic [4:0] PRM_RSVD_B = 5'h13;
	localparam logic [4:0] PRM_RSVD_C = 5'h14;
	localparam logic [4:0] PRM_RSVD_D = 5'h15;
	localparam logic [7:0] RST_LED12_SELECT = 8'h21;
	localparam logic [7:0] RST_LED3_SELECT = 8'h04;
	localparam logic [7:0] RST_RSVD_A = 8'h02;
	localparam logic [7:0] RST_RSVD_B = 8'h40;
	localparam logic [7:0] RST_PARAM = 8'h00;
	// serial slave address after reset; value arbitrary
	localparam logic [6:0] RST_BUS_ADDRESS = 7'h2A;
	// serial slave bit counting
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

//--- core/srsp_serial_slave.sv
// serial two-wire slave that moves bytes between the bus and a byte register port
`timescale 1ns/10ps
module srsp_serial_slave (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	input wire logic [6:0] i_dev_addr,
	output logic [7:0] o_addr,
	output logic o_wr,
	output logic [7:0] o_wdata,
	input wire logic [7:0] i_rdata
);
	import srsp_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_WDATA, S_WACK, S_RDATA, S_RACK} srsp_phase_t;
	typedef struct packed {
		logic scl;
		logic sda;
		srsp_phase_t phase;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic [7:0] ptr;
		logic rw;
		logic drive_low;
		logic wr;
		logic [7:0] wdata;
	} srsp_slave_t;

	srsp_slave_t q;
	srsp_slave_t next_q;
	logic rise;
	logic fall;
	logic start;
	logic stop;

	// bus edges and framing conditions
	assign rise = i_scl & ~q.scl;
	assign fall = ~i_scl & q.scl;
	assign start = i_scl & q.scl & q.sda & ~i_sda;
	assign stop = i_scl & q.scl & ~q.sda & i_sda;

	// protocol sequencer
	always_comb begin
		next_q = q;
		next_q.scl = i_scl;
		next_q.sda = i_sda;
		next_q.wr = 1'b0;
		if (start) begin
			next_q.phase = S_ADDR;
			next_q.cnt = 4'h0;
			next_q.drive_low = 1'b0;
		end else if (stop) begin
			next_q.phase = S_IDLE;
			next_q.drive_low = 1'b0;
		end else begin
			unique case (q.phase)
				S_IDLE: begin
					next_q.drive_low = 1'b0;
				end
				S_ADDR, S_PTR, S_WDATA: begin
					if (rise && q.cnt != BITS_PER_BYTE) begin
						next_q.shreg = {q.shreg[6:0], i_sda};
						next_q.cnt = q.cnt + 4'h1;
					end else if (fall && q.cnt == BITS_PER_BYTE) begin
						next_q.cnt = 4'h0;
						if (q.phase == S_ADDR) begin
							next_q.rw = q.shreg[0];
							next_q.phase = (q.shreg[7:1] == i_dev_addr) ? S_ADDR_ACK : S_IDLE;
							next_q.drive_low = (q.shreg[7:1] == i_dev_addr);
						end else begin
							next_q.phase = S_WACK;
							next_q.drive_low = 1'b1;
							if (q.phase == S_PTR) begin
								next_q.ptr = q.shreg;
							end else begin
								next_q.wr = 1'b1;
								next_q.wdata = q.shreg;
							end
						end
					end
				end
				S_ADDR_ACK, S_WACK: begin
					if (fall) begin
						next_q.cnt = 4'h0;
						next_q.drive_low = 1'b0;
						if (q.phase == S_WACK) begin
							next_q.phase = S_WDATA;
							if (q.wr) begin
								next_q.ptr = q.ptr + 8'h01;
							end
						end else if (q.rw) begin
							next_q.phase = S_RDATA;
							next_q.shreg = i_rdata;
							next_q.drive_low = ~i_rdata[7];
							next_q.cnt = 4'h1;
						end else begin
							next_q.phase = S_PTR;
						end
					end else if (q.wr) begin
						next_q.ptr = q.ptr + 8'h01; // write pointer steps after each stored byte
					end
				end
				S_RDATA: begin
					if (fall) begin
						if (q.cnt != BITS_PER_BYTE) begin
							next_q.drive_low = ~q.shreg[3'h7 - q.cnt[2:0]];
							next_q.cnt = q.cnt + 4'h1;
						end else begin
							next_q.drive_low = 1'b0;
							next_q.phase = S_RACK;
							next_q.ptr = q.ptr + 8'h01;
						end
					end
				end
				S_RACK: begin
					if (rise && i_sda) begin
						next_q.phase = S_IDLE; // host refused more data
					end else if (fall) begin
						next_q.phase = S_RDATA;
						next_q.shreg = i_rdata;
						next_q.drive_low = ~i_rdata[7];
						next_q.cnt = 4'h1;
					end
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			q <= '{scl: 1'b1, sda: 1'b1, phase: S_IDLE, cnt: 4'h0, shreg: 8'h00, ptr: 8'h00,
				rw: 1'b0, drive_low: 1'b0, wr: 1'b0, wdata: 8'h00};
		end else begin
			q <= next_q;
		end
	end

	// open-drain data pin and byte port
	assign o_sda = 1'b0;
	assign o_sda_oe_n = ~q.drive_low;
	assign o_addr = q.ptr;
	assign o_wr = q.wr;
	assign o_wdata = q.wdata;
endmodule

//--- core/srsp_reg_bank.sv
// result, mailbox, chip state and key registers with the indirect parameter memory
`timescale 1ns/10ps
module srsp_reg_bank (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	input wire logic i_aux_result_valid,
	input wire logic [15:0] i_aux_result,
	input wire logic i_awake,
	input wire logic i_suspend,
	input wire logic i_sleep,
	input wire logic i_parameter_read_command,
	input wire logic i_parameter_write_command,
	input wire logic i_apply_bus_address_command,
	input wire logic [4:0] i_param_offset,
	input wire logic [7:0] i_param_value,
	output logic [6:0] o_bus_address,
	output logic [7:0] o_channel_list,
	output logic [7:0] o_prox1_input_select,
	output logic [7:0] o_prox2_input_select,
	output logic [7:0] o_prox3_input_select,
	output logic [7:0] o_auxiliary_input_select,
	output logic [7:0] o_led12_select,
	output logic [7:0] o_led3_select
);
	import srsp_pkg::*;

	typedef struct packed {
		logic [7:0] aux_result_low;
		logic [7:0] aux_result_high;
		logic [7:0] parameter_readback_mailbox;
		logic [7:0] chip_state;
		logic [31:0] reserved_analog_key;
		logic [6:0] bus_address;
		logic [PARAM_DEPTH-1:0][7:0] param;
	} srsp_bank_t;

	// register that a serial-bus address selects
	typedef enum logic [2:0] {T_NONE, T_AUX_LOW, T_AUX_HIGH, T_MAILBOX, T_CHIP_STATE, T_KEY} srsp_target_t;

	srsp_bank_t q;
	srsp_bank_t next_q;
	logic [7:0] bus_addr;
	logic bus_wr;
	logic [7:0] bus_wdata;
	logic [7:0] bus_rdata;
	srsp_target_t bus_target;

	// byte lane of the key field for a bus address, most significant byte first
	function automatic logic [1:0] srsp_key_lane(input logic [7:0] addr);
		logic [7:0] diff;
		diff = addr - ADDR_KEY_FIRST;
		return 2'h3 - diff[1:0];
	endfunction

	// true when an address falls inside the key field
	function automatic logic srsp_is_key(input logic [7:0] addr);
		return (addr >= ADDR_KEY_FIRST) && (addr <= ADDR_KEY_LAST);
	endfunction

	// map a bus address onto its register; the read and write paths share this decode
	function automatic srsp_target_t srsp_decode(input logic [7:0] addr);
		srsp_target_t target;
		target = T_NONE;
		if (addr == ADDR_AUX_LOW) begin
			target = T_AUX_LOW;
		end else if (addr == ADDR_AUX_HIGH) begin
			target = T_AUX_HIGH;
		end else if (addr == ADDR_MAILBOX) begin
			target = T_MAILBOX;
		end else if (addr == ADDR_CHIP_STATE) begin
			target = T_CHIP_STATE;
		end else if (srsp_is_key(addr)) begin
			target = T_KEY;
		end
		return target;
	endfunction

	// reset image of the parameter memory
	function automatic logic [PARAM_DEPTH-1:0][7:0] srsp_param_reset();
		logic [PARAM_DEPTH-1:0][7:0] img;
		for (int i = 0; i < PARAM_DEPTH; i++) begin
			img[i] = RST_PARAM;
		end
		img[PRM_BUS_ADDRESS] = {1'b0, RST_BUS_ADDRESS};
		img[PRM_LED12_SELECT] = RST_LED12_SELECT;
		img[PRM_LED3_SELECT] = RST_LED3_SELECT;
		img[PRM_RSVD_A] = RST_RSVD_A;
		img[PRM_RSVD_B] = RST_RSVD_B;
		return img;
	endfunction

	// serial slave; parameter memory is not on its address map
	srsp_serial_slave u_srsp_serial_slave (
		.i_clock(i_clock),
		.i_srst(i_srst),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.o_sda(o_sda),
		.o_sda_oe_n(o_sda_oe_n),
		.i_dev_addr(q.bus_address),
		.o_addr(bus_addr),
		.o_wr(bus_wr),
		.o_wdata(bus_wdata),
		.i_rdata(bus_rdata)
	);

	// decoded register behind the current bus pointer
	assign bus_target = srsp_decode(bus_addr);

	// bus read multiplexer; unmapped and reserved bits read zero
	always_comb begin
		bus_rdata = 8'h00;
		unique case (bus_target)
			T_AUX_LOW: begin
				bus_rdata = q.aux_result_low;
			end
			T_AUX_HIGH: begin
				bus_rdata = q.aux_result_high;
			end
			T_MAILBOX: begin
				bus_rdata = q.parameter_readback_mailbox;
			end
			T_CHIP_STATE: begin
				bus_rdata = q.chip_state;
			end
			T_KEY: begin
				bus_rdata = q.reserved_analog_key[srsp_key_lane(bus_addr)*8 +: 8];
			end
			T_NONE: begin
				bus_rdata = 8'h00; // parameter offsets are not bus addresses
			end
		endcase
	end

	// register updates from the bus, the measurement side and the sequencer
	always_comb begin
		next_q = q;
		// chip state follows the power sequencer; upper bits stay zero
		next_q.chip_state = 8'h00;
		next_q.chip_state[STATE_AWAKE_BIT] = i_awake;
		next_q.chip_state[STATE_SUSPEND_BIT] = i_suspend;
		next_q.chip_state[STATE_SLEEP_BIT] = i_sleep;
		// host writes land one cycle after the slave's write strobe, which follows the scl fall after the data byte's eighth bit
		if (bus_wr) begin
			unique case (bus_target)
				T_AUX_LOW: begin
					next_q.aux_result_low = bus_wdata;
				end
				T_AUX_HIGH: begin
					next_q.aux_result_high = bus_wdata;
				end
				T_MAILBOX: begin
					next_q.parameter_readback_mailbox = bus_wdata;
				end
				T_KEY: begin
					next_q.reserved_analog_key[srsp_key_lane(bus_addr)*8 +: 8] = bus_wdata;
				end
				T_NONE, T_CHIP_STATE: begin
					// chip state is read only and parameters are off the bus
				end
			endcase
		end
		// a new measurement wins over a host write in the same cycle
		if (i_aux_result_valid) begin
			next_q.aux_result_low = i_aux_result[7:0];
			next_q.aux_result_high = i_aux_result[15:8];
		end
		// indirect parameter access
		if (i_parameter_write_command) begin
			next_q.param[i_param_offset] = i_param_value;
		end
		if (i_parameter_read_command) begin
			next_q.parameter_readback_mailbox = q.param[i_param_offset];
		end
		// stored address takes effect only on the apply command
		if (i_apply_bus_address_command) begin
			next_q.bus_address = q.param[PRM_BUS_ADDRESS][6:0];
		end
	end

	// state register
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			q.aux_result_low <= RST_AUX_LOW;
			q.aux_result_high <= RST_AUX_HIGH;
			q.parameter_readback_mailbox <= RST_MAILBOX;
			q.chip_state <= 8'h00;
			q.reserved_analog_key <= RST_KEY;
			q.bus_address <= RST_BUS_ADDRESS;
			q.param <= srsp_param_reset();
		end else begin
			q <= next_q;
		end
	end

	// parameter fields that steer the measurement side
	assign o_bus_address = q.bus_address;
	assign o_channel_list = q.param[PRM_CHANNEL_LIST];
	assign o_prox1_input_select = q.param[PRM_PROX1_INPUT_SELECT];
	assign o_prox2_input_select = q.param[PRM_PROX2_INPUT_SELECT];
	assign o_prox3_input_select = q.param[PRM_PROX3_INPUT_SELECT];
	assign o_auxiliary_input_select = q.param[PRM_AUXILIARY_INPUT_SELECT];
	assign o_led12_select = q.param[PRM_LED12_SELECT];
	assign o_led3_select = q.param[PRM_LED3_SELECT];
endmodule

//--- bench/srsp_monitor.sv
// checker for the command strobes and parameter outputs of the register bank
`timescale 1ns/10ps
module srsp_monitor (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_parameter_write_command,
	input wire logic i_apply_bus_address_command,
	input wire logic [4:0] i_param_offset,
	input wire logic [7:0] i_param_value,
	input wire logic [6:0] o_bus_address,
	input wire logic [7:0] o_channel_list,
	input wire logic [7:0] o_prox1_input_select,
	input wire logic [7:0] o_auxiliary_input_select
);
	import srsp_pkg::*;
	logic [6:0] addr_shadow;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_srst);
	// address value that the next apply command must copy out
	always_ff @(posedge i_clock) begin
		if (i_srst)
			addr_shadow <= RST_BUS_ADDRESS;
		else if (i_parameter_write_command && i_param_offset == PRM_BUS_ADDRESS)
			addr_shadow <= i_param_value[6:0];
	end
	// a set command, then its output one cycle later
	sequence s_set(logic [4:0] off);
		i_parameter_write_command && i_param_offset == off;
	endsequence
	property p_load(logic [4:0] off, logic [7:0] q);
		s_set(off) |=> q == $past(i_param_value);
	endproperty
	a_channel_list_load: assert property (p_load(PRM_CHANNEL_LIST, o_channel_list))
		else $error("channel list not loaded");
	a_prox1_load: assert property (p_load(PRM_PROX1_INPUT_SELECT, o_prox1_input_select))
		else $error("prox1 select not loaded");
	a_aux_load: assert property (p_load(PRM_AUXILIARY_INPUT_SELECT, o_auxiliary_input_select))
		else $error("aux select not loaded");
	a_params_quiet: assert property (!i_parameter_write_command |=> $stable({o_channel_list, o_prox1_input_select}))
		else $error("parameter moved without a command");
	a_address_hold: assert property (!i_apply_bus_address_command |=> $stable(o_bus_address))
		else $error("bus address moved without apply");
	a_address_apply: assert property (i_apply_bus_address_command |=> o_bus_address == $past(addr_shadow))
		else $error("bus address not applied");
endmodule

//--- bench/srsp_host_model.sv
// two-wire bus host that frames starts, stops and bytes
`timescale 1ns/10ps
module srsp_host_model (
	input wire logic i_clock,
	input wire logic i_sda_line,
	output logic o_scl,
	output logic o_sda_drv
);
	// both lines released at time zero
	initial begin
		o_scl = 1'b1;
		o_sda_drv = 1'b1;
	end
	// set both lines, then hold them three clocks
	task automatic step(input logic c, input logic d);
		o_scl <= c;
		o_sda_drv <= d;
		repeat (3) @(posedge i_clock);
	endtask
	task automatic start();
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask
	task automatic stop();
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask
	// eight bits msb first and the ack slot; data moves only while the clock is low
	task automatic xfer(input logic [7:0] w, input logic hack, output logic [7:0] r, output logic ack);
		logic [8:0] b;
		logic [8:0] s;
		b = {w, hack};
		for (int i = 8; i >= 0; i--) begin
			step(1'b0, b[i]);
			step(1'b1, b[i]);
			s[i] = i_sda_line;
			step(1'b0, b[i]);
		end
		r = s[8:1];
		ack = ~s[0];
	endtask
endmodule

//--- bench/sensor_result_status_param_map_test.sv
// self-checking bench for the result, status and parameter register bank
`timescale 1ns/10ps
module sensor_result_status_param_map_test;
	import srsp_pkg::*;
	logic i_clock = 1'b0;
	logic i_srst = 1'b1;
	logic scl, host_sda, o_sda, o_sda_oe_n, a, aux_vld, awake, suspend, sleep, rd_cmd, wr_cmd, ap_cmd;
	logic [15:0] aux = 16'h0000;
	logic [4:0] poff = 5'h00;
	logic [7:0] r, pval, channel_list, px1, px2, px3, auxsel, led12, led3;
	logic [6:0] bus_addr;
	logic [6:0] dev = RST_BUS_ADDRESS;
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [11:0] rows [8] = '{12'h000, 12'h101, 12'h202, 12'h303, 12'h404, 12'h505, 12'h606, 12'h707};
	logic [4:0] ofs [6] = '{5'h01, 5'h02, 5'h07, 5'h08, 5'h09, 5'h0F};
	// wired-and data line with pull-up
	wire sda_line = host_sda & (o_sda_oe_n | o_sda);
	srsp_reg_bank u_srsp_reg_bank (.i_clock(i_clock), .i_srst(i_srst), .i_scl(scl), .i_sda(sda_line),
		.o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_aux_result_valid(aux_vld), .i_aux_result(aux),
		.i_awake(awake), .i_suspend(suspend), .i_sleep(sleep), .i_parameter_read_command(rd_cmd),
		.i_parameter_write_command(wr_cmd), .i_apply_bus_address_command(ap_cmd), .i_param_offset(poff),
		.i_param_value(pval), .o_bus_address(bus_addr), .o_channel_list(channel_list), .o_prox1_input_select(px1),
		.o_prox2_input_select(px2), .o_prox3_input_select(px3), .o_auxiliary_input_select(auxsel),
		.o_led12_select(led12), .o_led3_select(led3));
	srsp_host_model u_srsp_host_model (.i_clock(i_clock), .i_sda_line(sda_line), .o_scl(scl), .o_sda_drv(host_sda));
	// clock and hang guard
	initial forever #2.5 i_clock = ~i_clock;
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			final_report();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// start, acknowledged address for writing, pointer byte
	task automatic hdr(input logic [7:0] ptr);
		u_srsp_host_model.start();
		u_srsp_host_model.xfer({dev, 1'b0}, 1'b1, r, a);
		chk({7'h00, a}, 8'h01);
		u_srsp_host_model.xfer(ptr, 1'b1, r, a);
		chk({7'h00, a}, 8'h01);
	endtask
	task automatic bus_write(input logic [7:0] ptr, input logic [7:0] d);
		hdr(ptr);
		u_srsp_host_model.xfer(d, 1'b1, r, a);
		u_srsp_host_model.stop();
	endtask
	// burst read of n bytes compared with exp, first byte in the top bits
	task automatic bus_read(input logic [7:0] ptr, input int n, input logic [31:0] exp);
		hdr(ptr);
		u_srsp_host_model.start();
		u_srsp_host_model.xfer({dev, 1'b1}, 1'b1, r, a);
		for (int k = 0; k < n; k++) begin
			u_srsp_host_model.xfer(8'hFF, k == n - 1, r, a);
			chk(r, exp[31 - 8 * k -: 8]);
		end
		u_srsp_host_model.stop();
	endtask
	// one command pulse, then one cycle for the result to land
	task automatic cmd(input logic [2:0] c, input logic [4:0] o, input logic [7:0] v);
		{rd_cmd, wr_cmd, ap_cmd} <= c;
		poff <= o;
		pval <= v;
		@(posedge i_clock);
		{rd_cmd, wr_cmd, ap_cmd} <= 3'h0;
		@(posedge i_clock);
	endtask
	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// main sequence
	initial begin
		{aux_vld, awake, suspend, sleep, rd_cmd, wr_cmd, ap_cmd} <= 7'h00;
		pval <= 8'h00;
		repeat (3) @(posedge i_clock);
		i_srst <= 1'b0;
		repeat (2) @(posedge i_clock);
		chk({1'b0, bus_addr}, 8'h2A);
		chk(led12, 8'h21);
		chk(led3, 8'h04);
		bus_read(8'h2C, 3, 32'h0);
		bus_read(8'h3B, 4, 32'h0);
		bus_write(8'h30, 8'hFF);
		foreach (rows[i]) begin
			{awake, suspend, sleep} <= rows[i][10:8];
			bus_read(8'h30, 1, {rows[i][7:0], 24'h0});
		end
		bus_read(8'h31, 1, 32'h0);
		// back-to-back results, the later wins; read before the next one
		{aux_vld, aux} <= 17'h1A55C;
		@(posedge i_clock);
		aux <= 16'h1234;
		@(posedge i_clock);
		aux_vld <= 1'b0;
		bus_read(8'h2C, 2, 32'h3412_0000);
		bus_write(8'h2D, 8'h3C);
		bus_read(8'h2C, 2, 32'h343C_0000);
		// reserved offsets left alone, reserved bits written as zero
		foreach (ofs[i]) cmd(3'h2, ofs[i], 8'(8'h41 + i));
		chk(channel_list, 8'h41);
		chk(led12, 8'h42);
		chk(px1, 8'h43);
		chk(px2, 8'h44);
		chk(px3, 8'h45);
		chk(auxsel, 8'h46);
		// a bus write to a parameter offset must not reach the parameter memory
		bus_write(8'h01, 8'hA5);
		chk(channel_list, 8'h41);
		// the mailbox is also writable by the host
		bus_write(8'h2E, 8'h77);
		bus_read(8'h2E, 1, 32'h7700_0000);
		cmd(3'h4, 5'h0F, 8'h00);
		bus_read(8'h2E, 1, 32'h4600_0000);
		cmd(3'h2, 5'h00, 8'h33);
		chk({1'b0, bus_addr}, 8'h2A);
		bus_read(8'h2E, 1, 32'h4600_0000);
		cmd(3'h1, 5'h00, 8'h00);
		chk({1'b0, bus_addr}, 8'h33);
		u_srsp_host_model.start();
		u_srsp_host_model.xfer({7'h2A, 1'b0}, 1'b1, r, a);
		u_srsp_host_model.stop();
		chk({7'h00, a}, 8'h00);
		dev = 7'h33;
		bus_read(8'h2E, 1, 32'h4600_0000);
		// mid-run reset brings back every default, reserved parameters included
		i_srst <= 1'b1;
		repeat (3) @(posedge i_clock);
		i_srst <= 1'b0;
		dev = RST_BUS_ADDRESS;
		@(posedge i_clock);
		chk({1'b0, bus_addr}, 8'h2A);
		chk(channel_list, 8'h00);
		chk(auxsel, 8'h00);
		chk(led12, 8'h21);
		bus_read(8'h2C, 3, 32'h0);
		cmd(3'h4, 5'h0D, 8'h00);
		bus_read(8'h2E, 1, 32'h0200_0000);
		cmd(3'h4, 5'h13, 8'h00);
		bus_read(8'h2E, 1, 32'h4000_0000);
		final_report();
	end
endmodule
bind srsp_reg_bank srsp_monitor u_srsp_monitor (.i_clock, .i_srst, .i_parameter_write_command,
	.i_apply_bus_address_command, .i_param_offset, .i_param_value, .o_bus_address, .o_channel_list,
	.o_prox1_input_select, .o_auxiliary_input_select);
